// File: rrso_decode.sv
// Opcode classifier for the return/rotate/subtract group.
// Assumes a stable instruction word; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module rrso_decode
   import rrso_pkg::*;
(
   input wire logic [RRSO_INSN_W-1:0] insn,
   output rrso_op_e op
);
   always_comb begin
      if (insn == RRSO_RETURN_WORD) begin
         op = RRSO_OP_RETURN;
      end else if (insn[13:10] == RRSO_RETLIT_TOP4) begin
         op = RRSO_OP_RETLIT;
      end else if (insn[13:9] == RRSO_LITSUB_TOP5) begin
         op = RRSO_OP_LITSUB;
      end else if (insn[13:8] == RRSO_ROTL_TOP6) begin
         op = RRSO_OP_ROTL;
      end else if (insn[13:8] == RRSO_ROTR_TOP6) begin
         op = RRSO_OP_ROTR;
      end else begin
         op = RRSO_OP_NONE;
      end
   end
endmodule
`default_nettype wire

// File: rrso_exec.sv
// Execution unit for literal return, plain return, rotates through carry and literal subtract.
// Assumes the core supplies register read data combinationally for insn's address,
// the stack top entry, and holds fetch while busy is high.
`timescale 1ns/10ps
`default_nettype none
module rrso_exec
   import rrso_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic insn_valid,
   input wire logic [RRSO_INSN_W-1:0] insn,
   input wire logic [RRSO_DATA_W-1:0] file_rdata,
   input wire logic [RRSO_PC_W-1:0] stack_top_entry,
   input wire logic carry_in,
   output logic [RRSO_DATA_W-1:0] acc_reg,
   output logic carry_reg,
   output logic nibble_carry_flag_reg,
   output logic zero_reg,
   output logic flags_we_reg,
   output logic [2:0] flags_mask_reg,
   output logic [RRSO_FADDR_W-1:0] file_addr_reg,
   output logic [RRSO_DATA_W-1:0] file_wdata_reg,
   output logic file_we_reg,
   output logic acc_we_reg,
   output logic stack_pop_reg,
   output logic pc_load_reg,
   output logic [RRSO_PC_W-1:0] pc_value_reg,
   output logic busy_reg,
   output logic done_reg
);
   rrso_op_e op;
   rrso_state_e state_reg;
   rrso_state_e state_next;
   logic issue;
   logic is_return;
   logic dest_file;
   logic [7:0] lit;
   logic [7:0] rot_l;
   logic [7:0] rot_r;
   logic [8:0] diff;
   logic [4:0] ndiff;

   rrso_decode u_decode (
      .insn(insn),
      .op(op)
   );

   // Flush cycle refuses whatever is offered
   assign issue = insn_valid && (state_reg == RRSO_ST_IDLE);
   // Both return kinds pop and need the flush cycle
   assign is_return = (op == RRSO_OP_RETLIT) || (op == RRSO_OP_RETURN);
   assign lit = insn[7:0];
   assign dest_file = insn[RRSO_DEST_BIT];
   assign rot_l = {file_rdata[6:0], carry_in};
   assign rot_r = {carry_in, file_rdata[7:1]};
   assign diff = {1'b0, lit} + {1'b0, ~acc_reg} + 9'h001;
   assign ndiff = {1'b0, lit[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;

   // second cycle of a return is a flush
   always_comb begin
      case (state_reg)
         RRSO_ST_IDLE: begin
            if (issue && is_return) begin
               state_next = RRSO_ST_FLUSH;
            end else begin
               state_next = RRSO_ST_IDLE;
            end
         end
         RRSO_ST_FLUSH: state_next = RRSO_ST_IDLE;
         default: state_next = RRSO_ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_reg <= RRSO_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Busy is high only in the flush cycle so the core stalls fetch
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         busy_reg <= (state_next == RRSO_ST_FLUSH);
         done_reg <= (issue && op != RRSO_OP_NONE && state_next == RRSO_ST_IDLE)
            || (state_reg == RRSO_ST_FLUSH);
      end
   end

   // Accumulator writes
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         acc_reg <= RRSO_ACC_RST;
         acc_we_reg <= 1'b0;
      end else begin
         acc_we_reg <= 1'b0;
         if (issue) begin
            case (op)
               RRSO_OP_RETLIT: begin
                  acc_reg <= lit;
                  acc_we_reg <= 1'b1;
               end
               RRSO_OP_ROTL: begin
                  if (!dest_file) begin
                     acc_reg <= rot_l;
                     acc_we_reg <= 1'b1;
                  end
               end
               RRSO_OP_ROTR: begin
                  if (!dest_file) begin
                     acc_reg <= rot_r;
                     acc_we_reg <= 1'b1;
                  end
               end
               RRSO_OP_LITSUB: begin
                  acc_reg <= diff[7:0];
                  acc_we_reg <= 1'b1;
               end
               default: begin
                  acc_we_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   // Register file write-back
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         file_addr_reg <= 7'h00;
         file_wdata_reg <= 8'h00;
         file_we_reg <= 1'b0;
      end else begin
         file_we_reg <= 1'b0;
         // 7-bit address field below destination bit
         // Address tracks insn freely; only the strobe qualifies it
         file_addr_reg <= insn[RRSO_FADDR_W-1:0];
         if (issue && dest_file && op == RRSO_OP_ROTL) begin
            file_wdata_reg <= rot_l;
            file_we_reg <= 1'b1;
         end else if (issue && dest_file && op == RRSO_OP_ROTR) begin
            file_wdata_reg <= rot_r;
            file_we_reg <= 1'b1;
         end
      end
   end

   // Status flags; mask bit0 carry, bit1 nibble carry, bit2 zero
   // Values hold between updates; core merges them by mask
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         carry_reg <= 1'b0;
         nibble_carry_flag_reg <= 1'b0;
         zero_reg <= 1'b0;
         flags_we_reg <= 1'b0;
         flags_mask_reg <= RRSO_ZERO3;
      end else begin
         flags_we_reg <= 1'b0;
         flags_mask_reg <= RRSO_ZERO3;
         if (issue) begin
            case (op)
               RRSO_OP_ROTL: begin
                  carry_reg <= file_rdata[7];
                  flags_we_reg <= 1'b1;
                  flags_mask_reg <= 3'h1;
               end
               RRSO_OP_ROTR: begin
                  carry_reg <= file_rdata[0];
                  flags_we_reg <= 1'b1;
                  flags_mask_reg <= 3'h1;
               end
               RRSO_OP_LITSUB: begin
                  carry_reg <= diff[8];
                  nibble_carry_flag_reg <= ndiff[4];
                  zero_reg <= (diff[7:0] == 8'h00);
                  flags_we_reg <= 1'b1;
                  flags_mask_reg <= 3'h7;
               end
               default: begin
                  flags_we_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   // plain return does the same, no flags
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         stack_pop_reg <= 1'b0;
         pc_load_reg <= 1'b0;
         pc_value_reg <= RRSO_PC_RST;
      end else begin
         stack_pop_reg <= 1'b0;
         pc_load_reg <= 1'b0;
         // Stack top taken at the issue edge, not in the flush
         if (issue && is_return) begin
            stack_pop_reg <= 1'b1;
            pc_load_reg <= 1'b1;
            pc_value_reg <= stack_top_entry;
         end
      end
   end
endmodule
`default_nettype wire

// File: rrso_exec_chk.sv
// Checker for the return, rotate and subtract unit.
// Bound to rrso_exec; watches its ports only.
`timescale 1ns/10ps
`default_nettype none
module rrso_exec_chk (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic insn_valid,
   input wire logic [13:0] insn,
   input wire logic [7:0] file_rdata,
   input wire logic [12:0] stack_top_entry,
   input wire logic carry_in,
   input wire logic [7:0] acc_reg,
   input wire logic carry_reg,
   input wire logic nibble_carry_flag_reg,
   input wire logic zero_reg,
   input wire logic flags_we_reg,
   input wire logic [2:0] flags_mask_reg,
   input wire logic [7:0] file_wdata_reg,
   input wire logic file_we_reg,
   input wire logic acc_we_reg,
   input wire logic stack_pop_reg,
   input wire logic pc_load_reg,
   input wire logic [12:0] pc_value_reg,
   input wire logic busy_reg,
   input wire logic done_reg
);
   // Flush cycle never takes an instruction
   wire go = insn_valid && !busy_reg;
   wire lw = go && insn[13:10] == 4'hd;
   wire rt = go && insn == 14'h0008;
   wire ro = go && insn[13:9] == 5'h06;
   wire sb = go && insn[13:9] == 5'h1e;
   // Top bit is the new carry
   wire [8:0] rot = insn[8] ? {file_rdata, carry_in} : {file_rdata[0], carry_in, file_rdata[7:1]};
   wire [9:0] sbv = {insn[3:0] >= acc_reg[3:0], insn[7:0] >= acc_reg, insn[7:0] - acc_reg};
   wire [7:0] lit = insn[7:0];
   wire dst = insn[7];
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence s_ret_tail;
      stack_pop_reg && pc_load_reg && busy_reg ##1 done_reg && !busy_reg && !stack_pop_reg;
   endsequence
   a_return_with_literal_op_acc_load: assert property (lw |=> acc_we_reg && !flags_we_reg && acc_reg == $past(lit))
      else $error("literal not loaded");
   a_ret_pop_pc: assert property (lw || rt |=> pc_value_reg == $past(stack_top_entry) ##0 s_ret_tail)
      else $error("return sequence wrong");
   a_ret_no_flags: assert property (rt |=> !flags_we_reg && !acc_we_reg)
      else $error("return touched state");
   a_rot_flag_mask: assert property (ro |=> flags_we_reg && flags_mask_reg == 3'h1)
      else $error("rotate flag mask");
   a_rot_to_file: assert property (ro && dst |=> file_we_reg && !acc_we_reg && {carry_reg, file_wdata_reg} == $past(rot))
      else $error("rotate to file");
   a_rot_to_acc: assert property (ro && !dst |=> acc_we_reg && !file_we_reg && {carry_reg, acc_reg} == $past(rot))
      else $error("rotate to acc");
   a_sub_result: assert property (sb |=> flags_mask_reg == 3'h7 && {nibble_carry_flag_reg, carry_reg, acc_reg} == $past(sbv) && zero_reg == (acc_reg == 8'h00))
      else $error("subtract result");
   a_one_cycle_done: assert property (ro || sb |=> done_reg && !busy_reg)
      else $error("single cycle op late");
   a_idle_quiet: assert property (!go |=> !file_we_reg && !acc_we_reg && !flags_we_reg && !stack_pop_reg)
      else $error("pulse without request");
endmodule
bind rrso_exec rrso_exec_chk u_chk (.*);
`default_nettype wire

// File: rrso_exec_tb.sv
// Self-checking bench for rrso_exec.
// Inputs change on the falling edge; the checker is bound in.
`timescale 1ns/10ps
`default_nettype none
module rrso_exec_tb;
   logic mclk = 1'b0, sys_rst = 1'b1, insn_valid = 1'b0, carry_in = 1'b0;
   logic [13:0] insn = 14'h0000;
   logic [7:0] file_rdata = 8'h00, acc_reg, file_wdata_reg;
   logic [12:0] stack_top_entry = 13'h0000, pc_value_reg;
   logic carry_reg, nibble_carry_flag_reg, zero_reg, flags_we_reg, file_we_reg, acc_we_reg;
   logic stack_pop_reg, pc_load_reg, busy_reg, done_reg;
   logic [2:0] flags_mask_reg;
   logic [6:0] file_addr_reg;
   int fail_count = 0, n_tests = 0, cycles = 0;
   always #10 mclk = ~mclk;
   rrso_exec dut (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .insn_valid(insn_valid),
      .insn(insn),
      .file_rdata(file_rdata),
      .stack_top_entry(stack_top_entry),
      .carry_in(carry_in),
      .acc_reg(acc_reg),
      .carry_reg(carry_reg),
      .nibble_carry_flag_reg(nibble_carry_flag_reg),
      .zero_reg(zero_reg),
      .flags_we_reg(flags_we_reg),
      .flags_mask_reg(flags_mask_reg),
      .file_addr_reg(file_addr_reg),
      .file_wdata_reg(file_wdata_reg),
      .file_we_reg(file_we_reg),
      .acc_we_reg(acc_we_reg),
      .stack_pop_reg(stack_pop_reg),
      .pc_load_reg(pc_load_reg),
      .pc_value_reg(pc_value_reg),
      .busy_reg(busy_reg),
      .done_reg(done_reg)
   );
   task automatic close_out;
      if (fail_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   // Ends on the falling edge after the taking edge
   task automatic go(input logic [13:0] i, input logic [7:0] fd, input logic c);
      insn_valid = 1'b1;
      insn = i;
      file_rdata = fd;
      carry_in = c;
      @(negedge mclk);
      insn_valid = 1'b0;
   endtask
   task automatic ret_run(input logic [13:0] i, input logic [12:0] sp, input logic aw, input logic [7:0] ea);
      stack_top_entry = sp;
      go(i, 8'h00, 1'b0);
      chk("pop", {3'h7, sp}, {stack_pop_reg, pc_load_reg, busy_reg, pc_value_reg});
      chk("acc", {1'b0, aw, ea}, {flags_we_reg, acc_we_reg, acc_reg});
      @(negedge mclk);
      chk("done", 3'b100, {done_reg, busy_reg, stack_pop_reg});
   endtask
   task automatic t_returns;
      ret_run(14'h3400, 13'h0000, 1'b1, 8'h00);
      ret_run(14'h37ff, 13'h1abc, 1'b1, 8'hff);
      ret_run(14'h0008, 13'h1fff, 1'b0, 8'hff);
   endtask
   task automatic t_rotates;
      logic [7:0] f, r;
      logic ce;
      for (int n = 0; n < 8; n++) begin
         f = (n[0] ^ n[1]) ? 8'he6 : 8'h19;
         {ce, r} = n[2] ? {f, n[1]} : {f[0], n[1], f[7:1]};
         go({5'h06, n[2], n[0], 7'h7f}, f, n[1]);
         chk("carry", {1'b1, 3'h1, ce, 7'h7f}, {flags_we_reg, flags_mask_reg, carry_reg, file_addr_reg});
         chk("dest", {~n[0], n[0], r}, {acc_we_reg, file_we_reg, n[0] ? file_wdata_reg : acc_reg});
         chk("rot_done", 1'b1, done_reg);
         // Idle edge keeps valid from being written twice in one step
         @(negedge mclk);
      end
   endtask
   task automatic t_sub;
      logic [7:0] ks [4] = '{8'h02, 8'h02, 8'h02, 8'h10};
      logic [7:0] ws [4] = '{8'h01, 8'h02, 8'h03, 8'h01};
      logic [7:0] d;
      for (int n = 0; n < 4; n++) begin
         ret_run({6'h34, ws[n]}, 13'h0000, 1'b1, ws[n]);
         go({5'h1e, n[0], ks[n]}, 8'h00, 1'b0);
         d = ks[n] - ws[n];
         chk("sub", {1'b1, 3'h7, ks[n] >= ws[n], ks[n][3:0] >= ws[n][3:0], d == 8'h00, d},
             {acc_we_reg, flags_mask_reg, carry_reg, nibble_carry_flag_reg, zero_reg, acc_reg});
         @(negedge mclk);
      end
   endtask
   // Rotate offered in the flush cycle must be dropped
   task automatic t_flush;
      stack_top_entry = 13'h0123;
      insn_valid = 1'b1;
      insn = 14'h0008;
      @(negedge mclk);
      chk("flush_pc", {1'b1, 13'h0123}, {pc_load_reg, pc_value_reg});
      insn = 14'h0dff;
      file_rdata = 8'h80;
      @(negedge mclk);
      chk("flush", 3'b100, {done_reg, file_we_reg, flags_we_reg});
      insn = 14'h0009;
      @(negedge mclk);
      insn_valid = 1'b0;
      chk("other", 3'b000, {done_reg, stack_pop_reg, acc_we_reg});
   endtask
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         close_out;
      end
   end
   initial begin
      repeat (6) @(negedge mclk);
      chk("rst", 16'h0000, {acc_reg, done_reg, busy_reg, stack_pop_reg, file_we_reg});
      sys_rst = 1'b0;
      t_returns;
      t_rotates;
      t_sub;
      t_flush;
      close_out;
   end
endmodule
`default_nettype wire

// File: rrso_pkg.sv
// Constants, opcode patterns and types for the return/rotate/subtract execution block.
// Assumes a 14-bit instruction word presented one per instruction cycle by the core.
package rrso_pkg;
   localparam int RRSO_INSN_W = 14;
   localparam int RRSO_DATA_W = 8;
   localparam int RRSO_FADDR_W = 7;
   localparam int RRSO_PC_W = 13;
   localparam int RRSO_DEST_BIT = 7;
   // Opcode match values on the upper instruction bits; plain return matches the whole word
   localparam logic [3:0] RRSO_RETLIT_TOP4 = 4'hd;
   localparam logic [4:0] RRSO_LITSUB_TOP5 = 5'h1e;
   localparam logic [5:0] RRSO_ROTL_TOP6 = 6'h0d;
   localparam logic [5:0] RRSO_ROTR_TOP6 = 6'h0c;
   localparam logic [13:0] RRSO_RETURN_WORD = 14'h0008;
   // Reset values
   localparam logic [7:0] RRSO_ACC_RST = 8'h00;
   localparam logic [RRSO_PC_W-1:0] RRSO_PC_RST = 13'h0000;
   localparam logic [2:0] RRSO_ZERO3 = 3'h0;
   typedef enum logic [1:0] {
      RRSO_ST_IDLE = 2'b00,
      RRSO_ST_FLUSH = 2'b01
   } rrso_state_e;
   typedef enum logic [2:0] {
      RRSO_OP_NONE = 3'b000,
      RRSO_OP_RETLIT = 3'b001,
      RRSO_OP_RETURN = 3'b010,
      RRSO_OP_ROTL = 3'b011,
      RRSO_OP_ROTR = 3'b100,
      RRSO_OP_LITSUB = 3'b101
   } rrso_op_e;
endpackage
